// ---- logic/imu_cal_ctrl.v ----
// Calibration, trim and output-resolution control of a six-axis sensor.
// Assumes an Avalon-MM master; sensor words and flash come from core logic.
`include "imu_cal_regs.vh"
module imu_cal_ctrl #(
  parameter FLASH_CYCLES = `FLASH_CYCLES
) (
  // Clock and reset
  input wire clk_in,
  input wire srst_in,
  // Avalon-MM slave
  input wire [7:0] address_in,
  input wire read_in,
  input wire write_in,
  input wire [31:0] writedata_in,
  output reg [31:0] readdata_out,
  output reg waitrequest_out,
  // Sensor core: primary and extended words for six axes
  input wire [95:0] sense_pri_in,
  input wire [95:0] sense_low_in,
  input wire [47:0] estimator_gyro_in,
  input wire sample_valid_in,
  input wire flash_done_in,
  // Controls toward the sensor core
  output reg pop_enable_out,
  output reg [10:0] decimation_setting_out,
  output reg [2:0] filter_size_out,
  output reg [95:0] trims_out,
  output reg flash_write_out,
  output reg sampling_run_out,
  output reg [5:0] growth_bits_out
);
  localparam ST_RUN = 3'b001;
  localparam ST_CLEAR = 3'b010;
  localparam ST_FLASH = 3'b100;

  reg [15:0] misc_control_reg_r;
  reg [15:0] filter_control_reg_r;
  reg [10:0] dec_r;
  reg [15:0] trim_r [0:5];
  reg [95:0] pri_r;
  reg [95:0] low_r;
  reg [2:0] state_r;
  reg [15:0] wait_cnt_r;
  reg busy_r;
  reg [11:0] sum_cnt;
  reg [5:0] growth_nxt;
  reg [15:0] rd_nxt;
  integer k;
  integer j;
  genvar g;

  wire wr_take = write_in & waitrequest_out;
  wire rd_take = read_in & waitrequest_out;
  wire [7:0] a = address_in;
  wire [6:0] byte_adr = writedata_in[`FRM_WR_BIT] ? writedata_in[14:8] : 7'h00;
  wire frame_wr = wr_take & writedata_in[`FRM_WR_BIT];
  wire [7:0] wbyte = writedata_in[7:0];

  always @* begin
    sum_cnt = {1'b0, dec_r} + (12'h001 << filter_size_out);
    growth_nxt = 6'h00;
    // Largest count is 2047 + 64, so the root stays below 64
    for (k = 1; k < 64; k = k + 1) begin
      if (k * k <= sum_cnt) begin
        growth_nxt = k[5:0];
      end
    end
  end

  always @* begin
    rd_nxt = 16'h0000;
    case (a)
      `OFF_MISC_CTRL: rd_nxt = misc_control_reg_r;
      `OFF_DEC_SET: rd_nxt = {5'h00, dec_r};
      `OFF_FILT_CTRL: rd_nxt = filter_control_reg_r;
      `OFF_GX_TRIM: rd_nxt = trim_r[0];
      `OFF_GY_TRIM: rd_nxt = trim_r[1];
      `OFF_GZ_TRIM: rd_nxt = trim_r[2];
      `OFF_AX_TRIM: rd_nxt = trim_r[3];
      `OFF_AY_TRIM: rd_nxt = trim_r[4];
      `OFF_AZ_TRIM: rd_nxt = trim_r[5];
      `OFF_STATUS: rd_nxt = {13'h0000, state_r};
      `OFF_GROWTH: rd_nxt = {10'h000, growth_bits_out};
      default: begin
        for (j = 0; j < 6; j = j + 1) begin
          if (a == `OFF_PRI_BASE + 2 * j) begin
            rd_nxt = pri_r[16 * j +: 16];
          end
          // Secondary words, growth bits from the top
          if (a == `OFF_LOW_BASE + 2 * j) begin
            rd_nxt = low_r[16 * j +: 16];
          end
        end
      end
    endcase
  end

  // Bus handshake: one wait cycle per access
  always @(posedge clk_in) begin
    if (srst_in) begin
      waitrequest_out <= 1'b1;
      readdata_out <= 32'h0000_0000;
    end else begin
      waitrequest_out <= ~(wr_take | rd_take);
      if (rd_take) begin
        readdata_out <= {16'h0000, rd_nxt};
      end
    end
  end

  // Trim registers and output words per axis
  generate
    for (g = 0; g < 6; g = g + 1) begin : axis
      wire [31:0] ev_full = `OFF_GX_TRIM + 2 * g;
      wire [7:0] ev = ev_full[7:0];
      always @(posedge clk_in) begin
        if (srst_in) begin
          trim_r[g] <= 16'h0000;
          pri_r[16 * g +: 16] <= 16'h0000;
          low_r[16 * g +: 16] <= 16'h0000;
        end else if (state_r == ST_CLEAR) begin
          trim_r[g] <= 16'h0000;
          pri_r[16 * g +: 16] <= 16'h0000;
          low_r[16 * g +: 16] <= 16'h0000;
        end else begin
          if (g < 3 && frame_wr && {1'b0, byte_adr} == `OFF_GLOBAL_CMD &&
              wbyte[`BIT_EST_LOAD]) begin
            trim_r[g] <= estimator_gyro_in[16 * (g % 3) +: 16];
          // Upper byte at odd address, az keeps 14 bits
          end else if (frame_wr && byte_adr == ev[6:0] + 7'h01) begin
            trim_r[g][15:8] <= (g == 5) ? {2'b00, wbyte[5:0]} : wbyte;
          end else if (frame_wr && byte_adr == ev[6:0]) begin
            trim_r[g][7:0] <= wbyte;
          end
          if (sample_valid_in && sampling_run_out) begin
            pri_r[16 * g +: 16] <= sense_pri_in[16 * g +: 16];
            low_r[16 * g +: 16] <= sense_low_in[16 * g +: 16];
          end
        end
      end
      always @(posedge clk_in) begin
        if (srst_in) begin
          trims_out[16 * g +: 16] <= 16'h0000;
        end else begin
          trims_out[16 * g +: 16] <= trim_r[g];
        end
      end
    end
  endgenerate

  // Configuration registers
  always @(posedge clk_in) begin
    if (srst_in) begin
      misc_control_reg_r <= `MISC_RESET;
      filter_control_reg_r <= `FILT_RESET;
      dec_r <= 11'h000;
    end else if (frame_wr) begin
      case ({1'b0, byte_adr})
        `OFF_MISC_CTRL: misc_control_reg_r[7:0] <= wbyte;
        `OFF_MISC_CTRL + 8'h01: misc_control_reg_r[15:8] <= wbyte;
        `OFF_DEC_SET: dec_r[7:0] <= wbyte;
        `OFF_DEC_SET + 8'h01: dec_r[10:8] <= wbyte[2:0];
        `OFF_FILT_CTRL: filter_control_reg_r[7:0] <=
          {5'h00, (wbyte[2:0] > `FILT_MAX) ? `FILT_MAX : wbyte[2:0]};
        `OFF_FILT_CTRL + 8'h01: filter_control_reg_r[15:8] <= {5'h00, wbyte[2:0]};
        default: ;
      endcase
    end
  end

  // Restore sequence
  always @(posedge clk_in) begin
    if (srst_in) begin
      state_r <= ST_RUN;
      wait_cnt_r <= 16'h0000;
      busy_r <= 1'b0;
    end else begin
      case (state_r)
        ST_RUN: begin
          if (frame_wr && {1'b0, byte_adr} == `OFF_GLOBAL_CMD && wbyte[`BIT_RESTORE]) begin
            state_r <= ST_CLEAR;
          end
        end
        ST_CLEAR: begin
          state_r <= ST_FLASH;
          wait_cnt_r <= FLASH_CYCLES[15:0];
        end
        ST_FLASH: begin
          if (flash_done_in || wait_cnt_r == 16'h0000) begin
            state_r <= ST_RUN;
          end else begin
            wait_cnt_r <= wait_cnt_r - 16'h0001;
          end
        end
        default: state_r <= ST_RUN;
      endcase
      busy_r <= (state_r != ST_RUN);
    end
  end

  // Registered outputs
  always @(posedge clk_in) begin
    if (srst_in) begin
      pop_enable_out <= 1'b0;
      decimation_setting_out <= 11'h000;
      filter_size_out <= 3'h0;
      flash_write_out <= 1'b0;
      sampling_run_out <= 1'b0;
      growth_bits_out <= 6'h00;
    end else begin
      pop_enable_out <= misc_control_reg_r[`BIT_POP];
      decimation_setting_out <= dec_r;
      filter_size_out <= filter_control_reg_r[`FILT_MSB:0];
      flash_write_out <= (state_r == ST_FLASH);
      sampling_run_out <= (state_r == ST_RUN) & ~busy_r;
      growth_bits_out <= growth_nxt;
    end
  end
endmodule // imu_cal_ctrl

// ---- common/imu_cal_regs.vh ----
// Register map and field constants for the calibration control block.
// Assumes byte addressed registers, one 16-bit value per aligned word.
`ifndef IMU_CAL_REGS_VH
`define IMU_CAL_REGS_VH
// Byte offsets of 16-bit registers (pair of byte addresses)
`define OFF_MISC_CTRL 8'h32
`define OFF_DEC_SET 8'h36
`define OFF_FILT_CTRL 8'h38
`define OFF_GLOBAL_CMD 8'h3E
`define OFF_GX_TRIM 8'h40
`define OFF_GY_TRIM 8'h42
`define OFF_GZ_TRIM 8'h44
`define OFF_AX_TRIM 8'h46
`define OFF_AY_TRIM 8'h48
`define OFF_AZ_TRIM 8'h4A
`define OFF_STATUS 8'h70
`define OFF_GROWTH 8'h72
`define OFF_PRI_BASE 8'h04
`define OFF_LOW_BASE 8'h10
// Fields
`define BIT_POP 6
`define BIT_EST_LOAD 0
`define BIT_RESTORE 1
`define DEC_MSB 10
`define FILT_MSB 2
`define FILT_MAX 3'h6
`define AZ_MSB 13
`define MISC_RESET 16'h00C1
`define FILT_RESET 16'h0500
`define FILT_MASK 16'h0707
// Frame layout
`define FRM_WR_BIT 15
// Flash commit time in cycles
`define FLASH_CYCLES 16'h0040
`endif

// ---- test/sensor_core_model.sv ----
// Sensor core model: steady sample words, sample strobe, flash completion.
// Assumes the clock of the control block.
module sensor_core_model (
  input wire logic clk_in,
  input wire logic flash_write_in,
  output logic [95:0] sense_pri_out,
  output logic [95:0] sense_low_out,
  output logic sample_valid_out,
  output logic flash_done_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt = 4'h0;
  logic [2:0] fcnt = 3'h0;
  assign sense_pri_out = {6{16'h1357}};
  assign sense_low_out = {6{16'hFC00}};
  always @(posedge clk_in) begin
    cnt <= cnt + 4'h1;
    sample_valid_out <= (cnt == 4'hF);
    fcnt <= flash_write_in ? fcnt + 3'h1 : 3'h0;
    flash_done_out <= (fcnt == 3'h2);
  end
endmodule // sensor_core_model

// ---- test/imu_cal_monitor.sv ----
// Checker for the calibration control block.
// Assumes a bind onto imu_cal_ctrl; sees only its ports.
module imu_cal_monitor #(parameter FLASH_CYCLES = 64) (
  input wire clk_in, srst_in, read_in, write_in, sample_valid_in, flash_done_in,
  input wire [7:0] address_in,
  input wire [31:0] writedata_in, readdata_out,
  input wire waitrequest_out, pop_enable_out, flash_write_out, sampling_run_out,
  input wire [95:0] sense_pri_in, sense_low_in, trims_out,
  input wire [47:0] estimator_gyro_in,
  input wire [10:0] decimation_setting_out,
  input wire [2:0] filter_size_out,
  input wire [5:0] growth_bits_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  wire tk = write_in && waitrequest_out;
  wire [7:0] fa = writedata_in[15:8];
  int summation_count;
  assign summation_count = decimation_setting_out + (1 << filter_size_out);
  ans_one_a: assert property (
    (read_in || write_in) && waitrequest_out |=> !waitrequest_out)
    else $error("no answer");
  pop_bit_a: assert property (
    tk && fa == 8'hB2 |=> ##1 pop_enable_out == $past(writedata_in[6], 2))
    else $error("pop bit");
  restore_clear_a: assert property (
    tk && writedata_in[15:0] == 16'hBE02 |-> ##[1:3] trims_out == 96'h0 && !sampling_run_out)
    else $error("restore");
  commit_end_a: assert property (
    $rose(flash_write_out) |-> ##[1:100] !flash_write_out)
    else $error("commit");
  resume_run_a: assert property (
    $fell(flash_write_out) |-> ##[0:2] sampling_run_out)
    else $error("resume");
  dec_low_a: assert property (
    tk && fa == 8'hB6 |=> ##1 decimation_setting_out[7:0] == $past(writedata_in[7:0], 2))
    else $error("decimation");
  filt_range_a: assert property (
    filter_size_out <= 3'h6)
    else $error("filter size");
  growth_val_a: assert property (
    ($stable(decimation_setting_out) && $stable(filter_size_out))[*3] |->
    growth_bits_out * growth_bits_out <= summation_count &&
    (growth_bits_out + 1) * (growth_bits_out + 1) > summation_count)
    else $error("growth");
  cover property (tk && writedata_in[15:0] == 16'hBE02);
  cover property ($fell(flash_write_out));
  cover property (growth_bits_out == 6'h06);
endmodule // imu_cal_monitor
bind imu_cal_ctrl imu_cal_monitor #(.FLASH_CYCLES(FLASH_CYCLES)) imu_cal_monitor_i (
  .clk_in(clk_in), .srst_in(srst_in), .read_in(read_in), .write_in(write_in),
  .sample_valid_in(sample_valid_in), .flash_done_in(flash_done_in), .address_in(address_in),
  .writedata_in(writedata_in), .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
  .pop_enable_out(pop_enable_out), .flash_write_out(flash_write_out),
  .sampling_run_out(sampling_run_out), .sense_pri_in(sense_pri_in),
  .sense_low_in(sense_low_in), .trims_out(trims_out), .estimator_gyro_in(estimator_gyro_in),
  .decimation_setting_out(decimation_setting_out), .filter_size_out(filter_size_out),
  .growth_bits_out(growth_bits_out));

// ---- test/imu_cal_ctrl_tb.sv ----
// Testbench for the calibration control block.
// Assumes the sensor core model and the bound checker.
module imu_cal_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'b0, srst_in = 1'b1, read_in = 1'b0, write_in = 1'b0;
  logic [7:0] address_in = 8'h00;
  logic [31:0] writedata_in = 32'h0000_0000;
  logic [47:0] estimator_gyro_in = 48'h0003_0002_0001;
  logic [31:0] rv;
  wire [31:0] readdata_out;
  wire [95:0] sense_pri_in, sense_low_in, trims_out;
  wire waitrequest_out, sample_valid_in, flash_done_in, pop_enable_out;
  wire flash_write_out, sampling_run_out;
  wire [10:0] decimation_setting_out;
  wire [2:0] filter_size_out;
  wire [5:0] growth_bits_out;
  int n_errors = 0, cmp_count = 0, cyc = 0;
  always #12.5 clk_in = ~clk_in;
  imu_cal_ctrl #(.FLASH_CYCLES(4)) imu_cal_ctrl_i (.clk_in(clk_in), .srst_in(srst_in),
    .address_in(address_in), .read_in(read_in), .write_in(write_in),
    .writedata_in(writedata_in), .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out), .sense_pri_in(sense_pri_in),
    .sense_low_in(sense_low_in), .estimator_gyro_in(estimator_gyro_in),
    .sample_valid_in(sample_valid_in), .flash_done_in(flash_done_in),
    .pop_enable_out(pop_enable_out), .decimation_setting_out(decimation_setting_out),
    .filter_size_out(filter_size_out), .trims_out(trims_out),
    .flash_write_out(flash_write_out), .sampling_run_out(sampling_run_out),
    .growth_bits_out(growth_bits_out));
  sensor_core_model sensor_core_model_i (.clk_in(clk_in), .flash_write_in(flash_write_out),
    .sense_pri_out(sense_pri_in), .sense_low_out(sense_low_in),
    .sample_valid_out(sample_valid_in), .flash_done_out(flash_done_in));
  task finish_test;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task chk(input string n, input [15:0] e, input [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // Avalon access held until waitrequest is seen low
  task acc(input bit w, input [7:0] a, input [15:0] d);
    write_in <= w;
    read_in <= !w;
    address_in <= a;
    writedata_in <= {16'h0000, d};
    @(posedge clk_in);
    while (waitrequest_out !== 1'b0) @(posedge clk_in);
    rv = readdata_out;
    write_in <= 1'b0;
    read_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task wr(input [15:0] f);
    acc(1'b1, 8'h00, f);
  endtask
  task rd(input [7:0] a, input [15:0] e);
    acc(1'b0, a, 16'h0000);
    chk($sformatf("reg_%h", a), e, rv[15:0]);
    chk($sformatf("reg_%h_upper", a), 16'h0000, rv[31:16]);
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    repeat (10) @(posedge clk_in);
    srst_in <= 1'b0;
    @(posedge clk_in);
    rd(8'h32, 16'h00C1);
    rd(8'h38, 16'h0500);
    rd(8'h72, 16'h0001);
    // Frames 0xC7 and 0xC6 address the trim word at byte offset 0x46
    wr(16'hC7FF);
    wr(16'hC6F4);
    rd(8'h46, 16'hFFF4);
    wr(16'h4612);
    rd(8'h46, 16'hFFF4);
    wr(16'hCBFF);
    wr(16'hCAF4);
    rd(8'h4A, 16'h3FF4);
    chk("trims_out_az", 16'h3FF4, trims_out[95:80]);
    wr(16'hB281);
    chk("pop_enable_out", 16'h0000, {15'h0000, pop_enable_out});
    rd(8'h32, 16'h0081);
    wr(16'hB2C1);
    chk("pop_enable_out", 16'h0001, {15'h0000, pop_enable_out});
    wr(16'hB604);
    wr(16'hB805);
    rd(8'h72, 16'h0006);
    wr(16'hB807);
    rd(8'h72, 16'h0008);
    wr(16'hB7FF);
    rd(8'h36, 16'h0704);
    rd(8'h72, 16'h002B);
    rd(8'h60, 16'h0000);
    wr(16'hBE01);
    rd(8'h40, 16'h0001);
    rd(8'h44, 16'h0003);
    wr(16'hBE02);
    rd(8'h04, 16'h0000);
    rd(8'h4A, 16'h0000);
    rd(8'h40, 16'h0000);
    repeat (200) @(posedge clk_in);
    rd(8'h70, 16'h0001);
    rd(8'h04, 16'h1357);
    rd(8'h10, 16'hFC00);
    finish_test();
  end
endmodule // imu_cal_ctrl_tb
